// ==== hw/frw_pkg.sv ====
package frw_pkg;
	// Rate codes of the two latched control bits
	typedef enum logic [1:0] {
		FRW_RATE_500 = 2'h0,
		FRW_RATE_300 = 2'h1,
		FRW_RATE_250 = 2'h2,
		FRW_RATE_125 = 2'h3
	} frw_rate_t;

	localparam logic [1:0] FRW_CTRL_RST       = 2'h0;
	localparam int         FRW_CLK_MHZ        = 125;
	localparam int         FRW_DRQ_DELAY_US   = 2;
	localparam int         FRW_DRQ_DELAY_CYC  = FRW_DRQ_DELAY_US * FRW_CLK_MHZ;
	localparam int         FRW_MCLK_HALF_CYC  = 2;
	localparam int         FRW_WCLK_HALF_CYC  = 16;
	localparam int         FRW_FCLK_HALF_CYC  = 8;
	localparam int         FRW_PRECOMP_STEP   = 4;
	localparam int         FRW_RD_PULSE_CYC   = 25;
	localparam int         FRW_FIFO_DEPTH     = 4;
endpackage

// ==== hw/frw_fifo.sv ====
module frw_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 4
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_size
		$error("frw_fifo: DEPTH must be a power of two >= 2");
	end

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0]      wp_r;
	logic [AW:0]      rp_r;
	logic             push;
	logic             pop;

	assign in_ready  = (wp_r - rp_r) != (AW+1)'(DEPTH);
	assign out_valid = wp_r != rp_r;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_r[rp_r[AW-1:0]];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			if (push)
				wp_r <= wp_r + 1'b1;
			if (pop)
				rp_r <= rp_r + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (push)
			mem_r[wp_r[AW-1:0]] <= in_data;
	end
endmodule

// ==== hw/frw_top.sv ====
// Behaviour
// [RQ1] Load strobe latches host data bits 0,1
// [RQ2] Speed select shows latched control bit 0
// [RQ3] Reset clears state, rate becomes 500
// [RQ4] DMA request delayed 2us, gated by enable
// [RQ5] Controller interrupt drives gated bus interrupt
// [RQ6] VCO enable 300 on 300 rate
// [RQ7] Other VCO enable on 500/250/125 rates
// [RQ8] Oscillator b for 300, a otherwise
// [RQ9] One open-drain pump pair per rate
// [RQ10] Read processing only while read enabled
// [RQ11] Shape read pulses, make read window clock
// [RQ12] Write data shifted by decoded precompensation
// [RQ13] Controller asserts write enable before writing
// [RQ14] Make write clock and controller clock
// [RQ15] Runs from 125 MHz source, monitor output
// [RQ16] Drive-type low means special drive
// [RQ17] Control bits map to rate codes 0..3
// [RQ18] Late pulse pumps up, early pulse down
module frw_top #(
	parameter int DRQ_DELAY_CYC = frw_pkg::FRW_DRQ_DELAY_CYC
) (
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	input  wire logic       master_reset_in,
	input  wire logic       crystal_pin,
	output logic            crystal_return,
	output logic            master_clock_monitor,
	input  wire logic       host_data_bit0,
	input  wire logic       host_data_bit1,
	input  wire logic       load_control_strobe,
	output logic            speed_select_out,
	input  wire logic       drive_type_in,
	output logic            special_drive,
	input  wire logic       rate_osc_a,
	input  wire logic       rate_osc_b,
	output logic            vco_enable_300,
	output logic            vco_enable_other_rates,
	input  wire logic       read_enable_in,
	input  wire logic       raw_read_in,
	output logic            shaped_read_data,
	output logic            read_window_clock,
	output logic      [3:0] pump_up_oe,
	output logic      [3:0] pump_down_oe,
	output logic      [3:0] pump_up_o,
	output logic      [3:0] pump_down_o,
	input  wire logic       write_data_in,
	input  wire logic       write_enable_in,
	input  wire logic       precomp_sel0,
	input  wire logic       precomp_sel1,
	output logic            precomp_write_out,
	output logic            write_clock_out,
	output logic            controller_clock_out,
	input  wire logic       controller_dma_request_in,
	input  wire logic       controller_irq_in,
	input  wire logic       bus_gate_enable,
	input  wire logic       bus_dma_ack_in,
	output logic            bus_dma_request_o,
	output logic            bus_dma_request_oe,
	output logic            bus_irq_o,
	output logic            bus_irq_oe
);
	localparam int DW = $clog2(DRQ_DELAY_CYC + 1);
	localparam int PW = $clog2(3 * frw_pkg::FRW_PRECOMP_STEP + 2);

	if (DRQ_DELAY_CYC < 1) begin : g_bad_delay
		$error("frw_top: DRQ_DELAY_CYC must be at least 1");
	end

	// ------------------------------------------------------------
	// Reset and input synchronisers
	// ------------------------------------------------------------
	logic [1:0] rst_sync_r;
	logic       rst_n;
	localparam int NS = 15;
	// Drive-type pin idles high through its pull-up
	localparam logic [NS-1:0] PIN_RST = 15'h0400;
	// Three flops per pin; a level counts once flops two and three agree
	logic [NS-1:0] pin_in;
	logic [NS-1:0] s1_r;
	logic [NS-1:0] s2_r;
	logic [NS-1:0] s3_r;
	logic [NS-1:0] pin_r;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			rst_sync_r <= 2'h0;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end

	assign pin_in = {master_reset_in, host_data_bit0, host_data_bit1, load_control_strobe,
		drive_type_in, rate_osc_a, rate_osc_b, read_enable_in, raw_read_in,
		write_data_in, controller_dma_request_in, controller_irq_in, write_enable_in,
		precomp_sel1, precomp_sel0};

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s1_r  <= PIN_RST;
			s2_r  <= PIN_RST;
			s3_r  <= PIN_RST;
			pin_r <= PIN_RST;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			for (int i = 0; i < NS; i++) begin
				if (s2_r[i] == s3_r[i])
					pin_r[i] <= s3_r[i];
			end
		end
	end

	logic mr_s;
	logic d0_s;
	logic d1_s;
	logic ld_s;
	logic drv_s;
	logic osca_s;
	logic oscb_s;
	logic rden_s;
	logic raw_s;
	logic wda_s;
	logic drq_s;
	logic int_s;
	logic we_s;
	logic ps1_s;
	logic ps0_s;
	assign {mr_s, d0_s, d1_s, ld_s, drv_s, osca_s, oscb_s, rden_s, raw_s, wda_s,
		drq_s, int_s, we_s, ps1_s, ps0_s} = pin_r;

	// Master reset clears all state except the clock dividers and input synchronisers
	assign rst_n = rst_sync_r[1] && !mr_s; // [RQ3]

	// ------------------------------------------------------------
	// Control register and rate decode
	// ------------------------------------------------------------
	logic [1:0]        ctrl_r;
	frw_pkg::frw_rate_t rate;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			ctrl_r <= frw_pkg::FRW_CTRL_RST; // [RQ3]
		else if (!rst_n)
			ctrl_r <= frw_pkg::FRW_CTRL_RST; // [RQ3]
		else if (ld_s)
			ctrl_r <= {d1_s, d0_s}; // [RQ1]
	end

	assign rate                   = frw_pkg::frw_rate_t'(ctrl_r); // [RQ17]
	assign speed_select_out       = ctrl_r[0]; // [RQ2]
	assign vco_enable_300         = rate == frw_pkg::FRW_RATE_300; // [RQ6]
	assign vco_enable_other_rates = rate != frw_pkg::FRW_RATE_300; // [RQ7]
	assign special_drive          = !drv_s; // [RQ16]

	// Selected rate oscillator and its rising edge
	logic osc_sel;
	logic osc_d_r;
	logic osc_rise;
	assign osc_sel  = vco_enable_300 ? oscb_s : osca_s; // [RQ8]
	assign osc_rise = osc_sel && !osc_d_r;

	// ------------------------------------------------------------
	// Clock generation from the 125 MHz source
	// ------------------------------------------------------------
	logic [4:0] mdiv_r;
	logic       mclk_r;
	logic [4:0] wdiv_r;
	logic       wclk_r;
	logic [3:0] fdiv_r;
	logic       fclk_r;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			mdiv_r <= '0;
			mclk_r <= 1'b0;
			wdiv_r <= '0;
			wclk_r <= 1'b0;
			fdiv_r <= '0;
			fclk_r <= 1'b0;
			osc_d_r <= 1'b0;
		end else begin
			osc_d_r <= osc_sel;
			if (mdiv_r == 5'(frw_pkg::FRW_MCLK_HALF_CYC - 1)) begin
				mdiv_r <= '0;
				mclk_r <= !mclk_r;
			end else
				mdiv_r <= mdiv_r + 5'h01;
			if (wdiv_r == 5'(frw_pkg::FRW_WCLK_HALF_CYC - 1)) begin
				wdiv_r <= '0;
				wclk_r <= !wclk_r; // [RQ14]
			end else
				wdiv_r <= wdiv_r + 5'h01;
			if (fdiv_r == 4'(frw_pkg::FRW_FCLK_HALF_CYC - 1)) begin
				fdiv_r <= '0;
				fclk_r <= !fclk_r; // [RQ14]
			end else
				fdiv_r <= fdiv_r + 4'h1;
		end
	end

	assign crystal_return       = !crystal_pin; // [RQ15]
	assign master_clock_monitor = mclk_r; // [RQ15]
	assign write_clock_out      = wclk_r;
	assign controller_clock_out = fclk_r;

	// ------------------------------------------------------------
	// Read path: window, shaping, pump
	// ------------------------------------------------------------
	logic       win_r;
	logic       raw_d_r;
	logic       raw_rise;
	logic [4:0] rpw_r;
	logic       rd_data_r;
	logic [3:0] up_r;
	logic [3:0] dn_r;
	logic       fifo_in_ready;
	logic       fifo_out_valid;

	assign raw_rise = raw_s && !raw_d_r;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			win_r     <= 1'b0;
			raw_d_r   <= 1'b0;
			rpw_r     <= '0;
			rd_data_r <= 1'b0;
			up_r      <= '0;
			dn_r      <= '0;
		end else if (!rst_n || !rden_s) begin // [RQ10]
			win_r     <= 1'b0;
			raw_d_r   <= raw_s;
			rpw_r     <= '0;
			rd_data_r <= 1'b0;
			up_r      <= '0;
			dn_r      <= '0;
		end else begin
			raw_d_r <= raw_s;
			if (osc_rise)
				win_r <= !win_r; // [RQ11]
			if (fifo_out_valid && rpw_r == '0) begin
				rpw_r     <= 5'(frw_pkg::FRW_RD_PULSE_CYC);
				rd_data_r <= 1'b1; // [RQ11]
			end else if (rpw_r != '0) begin
				rpw_r <= rpw_r - 5'h01;
				if (rpw_r == 5'h01)
					rd_data_r <= 1'b0;
			end
			if (ld_s) begin
				up_r <= '0; // [RQ9]
				dn_r <= '0;
			end else if (raw_rise) begin
				up_r <= '0;
				dn_r <= '0;
				up_r[ctrl_r] <= win_r; // [RQ18]
				dn_r[ctrl_r] <= !win_r; // [RQ9]
			end else if (osc_rise) begin
				up_r <= '0;
				dn_r <= '0;
			end
		end
	end

	frw_fifo #(
		.WIDTH (1),
		.DEPTH (frw_pkg::FRW_FIFO_DEPTH)
	) u_rd_fifo (
		.clk       (ref_clk),
		.rst_n     (rst_n),
		.in_valid  (raw_rise && rden_s),
		.in_ready  (fifo_in_ready),
		.in_data   (win_r),
		.out_valid (fifo_out_valid),
		.out_ready (rpw_r == '0),
		.out_data  ()
	);

	assign shaped_read_data  = rd_data_r;
	assign read_window_clock = win_r; // [RQ11]
	assign pump_up_o         = 4'h0;
	assign pump_down_o       = 4'h0;
	assign pump_up_oe        = up_r; // [RQ9]
	assign pump_down_oe      = dn_r; // [RQ9]

	// ------------------------------------------------------------
	// Write precompensation
	// ------------------------------------------------------------
	logic [PW-1:0] pc_delay;
	logic [PW-1:0] pc_cnt_r;
	logic          wda_d_r;
	logic          wpulse_r;

	assign pc_delay = PW'({ps1_s, ps0_s}) * PW'(frw_pkg::FRW_PRECOMP_STEP) + PW'(1);

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pc_cnt_r <= '0;
			wda_d_r  <= 1'b0;
			wpulse_r <= 1'b0;
		end else if (!rst_n) begin
			pc_cnt_r <= '0;
			wda_d_r  <= 1'b0;
			wpulse_r <= 1'b0;
		end else begin
			wda_d_r  <= wda_s;
			wpulse_r <= 1'b0;
			if (wda_s && !wda_d_r && we_s) // [RQ13]
				pc_cnt_r <= pc_delay; // [RQ12]
			else if (pc_cnt_r != '0) begin
				pc_cnt_r <= pc_cnt_r - PW'(1);
				if (pc_cnt_r == PW'(1))
					wpulse_r <= 1'b1; // [RQ12]
			end
		end
	end

	assign precomp_write_out = wpulse_r;

	// ------------------------------------------------------------
	// Bus DMA request delay and interrupt gating
	// ------------------------------------------------------------
	logic [DW-1:0] dly_r;
	logic          drq_dly_r;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			dly_r     <= '0;
			drq_dly_r <= 1'b0;
		end else if (!rst_n || !drq_s) begin
			dly_r     <= '0;
			drq_dly_r <= 1'b0;
		end else if (dly_r == DW'(DRQ_DELAY_CYC - 1))
			drq_dly_r <= 1'b1; // [RQ4]
		else
			dly_r <= dly_r + DW'(1);
	end

	assign bus_dma_request_o  = drq_dly_r; // [RQ4]
	assign bus_dma_request_oe = bus_gate_enable; // [RQ4]
	assign bus_irq_o          = int_s; // [RQ5]
	assign bus_irq_oe         = bus_gate_enable; // [RQ5]
endmodule

// ==== verif/frw_top_chk.sv ====
module frw_top_chk #(
	parameter int DRQ_DELAY_CYC = 250
) (
	input wire logic       ref_clk,
	input wire logic       nrst,
	input wire logic       master_reset_in,
	input wire logic       drive_type_in,
	input wire logic       special_drive,
	input wire logic       vco_enable_300,
	input wire logic       vco_enable_other_rates,
	input wire logic       read_enable_in,
	input wire logic       read_window_clock,
	input wire logic [3:0] pump_up_oe,
	input wire logic [3:0] pump_down_oe,
	input wire logic       controller_dma_request_in,
	input wire logic       controller_irq_in,
	input wire logic       bus_gate_enable,
	input wire logic       bus_dma_request_o,
	input wire logic       bus_dma_request_oe,
	input wire logic       bus_irq_o,
	input wire logic       bus_irq_oe
);
	logic [8:0] hi_r;
	logic [7:0] off_r;
	logic [3:0] up_r;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// ---
	// Input history counters
	// ---
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			hi_r  <= 9'h000;
			off_r <= 8'h00;
			up_r  <= 4'h0;
		end else begin
			hi_r  <= !controller_dma_request_in ? 9'h000 : hi_r + 9'(hi_r != 9'h1FF);
			off_r <= read_enable_in ? 8'h00 : off_r + 8'(off_r != 8'hFF);
			up_r  <= master_reset_in ? 4'h0 : up_r + 4'(up_r != 4'hF);
		end
	end
	AST_DRQ_OE: assert property (bus_dma_request_oe == bus_gate_enable)
		else $error("dma request enable wrong");
	AST_IRQ_OE: assert property (bus_irq_oe == bus_gate_enable)
		else $error("irq enable wrong");
	AST_VCO_ONE: assert property (up_r == 4'hF |->
		vco_enable_300 ^ vco_enable_other_rates) else $error("vco enables not exclusive");
	AST_PUMP_ONE: assert property ($onehot0(pump_up_oe | pump_down_oe))
		else $error("two pump outputs active");
	AST_READ_IDLE: assert property (off_r >= 8'h64 |->
		!read_window_clock && (pump_up_oe | pump_down_oe) == 4'h0) else $error("read path busy");
	AST_DRQ_DELAY: assert property ($rose(bus_dma_request_o) |->
		hi_r >= DRQ_DELAY_CYC && hi_r <= DRQ_DELAY_CYC + 8) else $error("dma delay wrong");
	AST_DRQ_FALL: assert property ($fell(controller_dma_request_in) |->
		##[1:8] !bus_dma_request_o) else $error("dma request stuck");
	AST_IRQ_HI: assert property ((controller_irq_in && bus_gate_enable)[*8] |-> bus_irq_o)
		else $error("irq not passed");
	AST_DRIVE_LOW: assert property (!drive_type_in[*8] |-> special_drive)
		else $error("special drive not flagged");
	AST_DRIVE_HIGH: assert property (drive_type_in[*8] |-> !special_drive)
		else $error("special drive without low input");
	AST_MR_RATE: assert property ($fell(master_reset_in) |->
		##[4:8] (vco_enable_other_rates && !vco_enable_300)) else $error("rate not back to 500");
endmodule

bind frw_top frw_top_chk #(.DRQ_DELAY_CYC(DRQ_DELAY_CYC)) frw_top_chk_inst (
	.ref_clk                   (ref_clk),
	.nrst                      (nrst),
	.master_reset_in           (master_reset_in),
	.drive_type_in             (drive_type_in),
	.special_drive             (special_drive),
	.vco_enable_300            (vco_enable_300),
	.vco_enable_other_rates    (vco_enable_other_rates),
	.read_enable_in            (read_enable_in),
	.read_window_clock         (read_window_clock),
	.pump_up_oe                (pump_up_oe),
	.pump_down_oe              (pump_down_oe),
	.controller_dma_request_in (controller_dma_request_in),
	.controller_irq_in         (controller_irq_in),
	.bus_gate_enable           (bus_gate_enable),
	.bus_dma_request_o         (bus_dma_request_o),
	.bus_dma_request_oe        (bus_dma_request_oe),
	.bus_irq_o                 (bus_irq_o),
	.bus_irq_oe                (bus_irq_oe)
);

// ==== verif/frw_far_model.sv ====
module frw_far_model #(
	parameter int A_HALF = 30,
	parameter int B_HALF = 25
) (
	input  wire logic ref_clk,
	input  wire logic fire,
	output logic      rate_osc_a,
	output logic      rate_osc_b,
	output logic      raw_read
);
	timeunit 1ns;
	timeprecision 1ps;
	int ca, cb, cr;
	initial {rate_osc_a, rate_osc_b, raw_read, ca, cb, cr} = '0;
	// ---
	// Free running oscillators, b at 1.2x a
	// ---
	always @(posedge ref_clk) begin
		ca <= (ca == A_HALF - 1) ? 0 : ca + 1;
		cb <= (cb == B_HALF - 1) ? 0 : cb + 1;
		rate_osc_a <= rate_osc_a ^ (ca == A_HALF - 1);
		rate_osc_b <= rate_osc_b ^ (cb == B_HALF - 1);
		cr <= fire ? 2 : (cr != 0 ? cr - 1 : 0);
		raw_read <= fire || cr != 0;
	end
endmodule

// ==== verif/frw_top_tb_top.sv ====
module frw_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       ref_clk, nrst, master_reset_in, crystal_pin, crystal_return;
	logic       master_clock_monitor, host_data_bit0, host_data_bit1;
	logic       load_control_strobe, speed_select_out, drive_type_in, special_drive;
	logic       rate_osc_a, rate_osc_b, vco_enable_300, vco_enable_other_rates;
	logic       read_enable_in, raw_read_in, shaped_read_data, read_window_clock;
	logic [3:0] pump_up_oe, pump_down_oe, pump_up_o, pump_down_o, seen;
	logic       write_data_in, write_enable_in, precomp_sel0, precomp_sel1;
	logic       precomp_write_out, write_clock_out, controller_clock_out, fire;
	logic       controller_dma_request_in, controller_irq_in, bus_gate_enable;
	logic       bus_dma_ack_in, bus_dma_request_o, bus_dma_request_oe, bus_irq_o, bus_irq_oe;
	logic [4:0] sig, prv;
	int         e[5], s[5], n_mismatch, checks_done, d, d0, hc, h;
	frw_top #(.DRQ_DELAY_CYC(250)) frw_top_inst (.*);
	frw_far_model #(.A_HALF(30), .B_HALF(25)) frw_far_model_inst (.ref_clk(ref_clk),
		.fire(fire), .rate_osc_a(rate_osc_a), .rate_osc_b(rate_osc_b), .raw_read(raw_read_in));
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	// ---
	// Rising edge counters
	// ---
	assign sig = {shaped_read_data, read_window_clock, master_clock_monitor,
		controller_clock_out, write_clock_out};
	always @(posedge ref_clk) begin
		prv <= sig;
		crystal_pin <= ~crystal_pin;
		for (int i = 0; i < 5; i++)
			if (sig[i] && !prv[i])
				e[i]++;
	end
	task automatic chk(input logic ok, input string m);
		checks_done++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic test_done();
		if (n_mismatch == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic load(input logic [1:0] c);
		@(posedge ref_clk);
		{host_data_bit1, host_data_bit0} <= c;
		load_control_strobe <= 1'b1;
		cyc(8);
		load_control_strobe <= 1'b0;
		cyc(8);
	endtask
	task automatic rate(input logic [1:0] c);
		chk(speed_select_out === c[0], "speed select");
		chk(vco_enable_300 === (c == 2'h1), "vco 300");
		chk(vco_enable_other_rates === (c != 2'h1), "vco other");
	endtask
	task automatic span(input int n);
		@(negedge ref_clk);
		s = e;
		repeat (n) @(negedge ref_clk);
		for (int i = 0; i < 5; i++)
			s[i] = e[i] - s[i];
	endtask
	task automatic shot();
		@(posedge ref_clk);
		fire <= 1'b1;
		@(posedge ref_clk);
		fire <= 1'b0;
	endtask
	task automatic watch(input int n);
		seen = 4'h0;
		hc = 0;
		repeat (n) begin
			@(negedge ref_clk);
			seen |= pump_up_oe | pump_down_oe;
			hc += int'(shaped_read_data);
		end
		@(posedge ref_clk);
	endtask
	task automatic wpulse();
		@(posedge ref_clk);
		write_data_in <= 1'b1;
		d = 0;
		do begin
			@(negedge ref_clk);
			d++;
		end while (precomp_write_out !== 1'b1 && d < 60);
		cyc(1);
		write_data_in <= 1'b0;
		cyc(20);
	endtask
	initial begin
		cyc(60000);
		n_mismatch++;
		test_done();
	end
	initial begin
		{nrst, master_reset_in, crystal_pin, host_data_bit0, host_data_bit1, fire} = '0;
		{load_control_strobe, read_enable_in, write_data_in, write_enable_in} = '0;
		{precomp_sel0, precomp_sel1, controller_dma_request_in, controller_irq_in} = '0;
		{bus_gate_enable, bus_dma_ack_in} = '0;
		drive_type_in = 1'b1;
		cyc(20);
		nrst <= 1'b1;
		cyc(10);
		rate(2'h0);
		read_enable_in <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			load(2'(c));
			rate(2'(c));
			h = (c == 1) ? 25 : 30;
			span(3000);
			chk(s[3] >= 3000 / (4 * h) - 1 && s[3] <= 3000 / (4 * h) + 1, "window");
			shot();
			watch(100);
			chk(seen === 4'h1 << c, "pump pair");
			chk(hc == frw_pkg::FRW_RD_PULSE_CYC, "read pulse");
		end
		read_enable_in <= 1'b0;
		cyc(10);
		shot();
		watch(100);
		chk(seen === 4'h0 && hc == 0, "read off");
		read_enable_in <= 1'b1;
		cyc(10);
		@(negedge ref_clk);
		d = e[4];
		repeat (12) begin
			shot();
			cyc(4);
		end
		cyc(600);
		@(negedge ref_clk);
		d = e[4] - d;
		chk(d > frw_pkg::FRW_FIFO_DEPTH && d < 12, "fifo");
		load(2'h1);
		master_reset_in <= 1'b1;
		cyc(6);
		master_reset_in <= 1'b0;
		cyc(20);
		rate(2'h0);
		read_enable_in <= 1'b0;
		write_enable_in <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			{precomp_sel1, precomp_sel0} <= 2'(k);
			cyc(8);
			wpulse();
			d0 = (k == 0) ? d : d0;
			chk(d < 60 && d - d0 == k * frw_pkg::FRW_PRECOMP_STEP, "precomp");
		end
		write_enable_in <= 1'b0;
		wpulse();
		chk(d == 60, "write off");
		bus_gate_enable <= 1'b1;
		controller_dma_request_in <= 1'b1;
		d = 0;
		while (bus_dma_request_o !== 1'b1 && d < 400) begin
			@(negedge ref_clk);
			d++;
		end
		chk(d >= 250 && d <= 258, "dma delay");
		@(posedge ref_clk);
		controller_dma_request_in <= 1'b0;
		controller_irq_in <= 1'b1;
		cyc(10);
		chk(bus_dma_request_o === 1'b0 && bus_irq_o === 1'b1, "bus pass");
		bus_gate_enable <= 1'b0;
		drive_type_in <= 1'b0;
		cyc(10);
		chk(bus_irq_oe === 1'b0 && bus_dma_request_oe === 1'b0, "bus gate");
		chk(special_drive === 1'b1, "drive type");
		controller_irq_in <= 1'b0;
		span(320);
		chk(s[0] == 320 / (2 * frw_pkg::FRW_WCLK_HALF_CYC), "write clock");
		chk(s[1] == 320 / (2 * frw_pkg::FRW_FCLK_HALF_CYC), "ctrl clock");
		chk(s[2] == 320 / (2 * frw_pkg::FRW_MCLK_HALF_CYC), "monitor");
		chk(crystal_return === ~crystal_pin, "crystal");
		test_done();
	end
endmodule
